/* File: dual_timer_common_control.sv */
// dual timer common control: count sources, buffer transfer, lockstep, cutoff
// Behaviour
// - source 110b counts the 40 MHz oscillator, 111b the fast oscillator
// - source 101b with external enable counts external pin on selected edge
// - external pin is never a count source in fixed-period dual PWM mode
// - register C buffers A and D buffers B, each with its own enable
// - capture with buffering copies old A or B into its buffer
// - compare or PWM with buffering loads A or B from buffer on match
// - reset-sync PWM reloads A and B on counter zero matching channel zero A
// - complementary PWM reloads B0, A1, B1 on zero-A match and counter one underflow
// - fixed-period PWM reloads all A and B on counter zero matching A0
// - capture buffering sets C and D flags on the C pin input edge
// - compare buffering sets C and D flags on counter matching buffers
// - with lockstep on, writing either counter writes both
// - lockstep with clear source 011b clears together with the other counter
// - clear source 001b clears the counter on a register A capture
// - each output pin drives the waveform only while its disable bit is zero
// - enabled cutoff with low interrupt pin sets every output disable bit, except in capture mode
// - outputs return to port control one to two operation clocks after low
// - operation clock is system clock except for oscillator and external source codes
// - two independent 16-bit up-counting channels, zero and one
module dual_timer_common_control
  import dual_timer_pkg::*;
#(
  parameter int CH = CHANNELS
) (
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     osc_40mhz_tick,
  input  wire logic                     fast_osc_tick,
  input  wire logic                     sys_div_tick,
  input  wire logic                     ext_count_clock_pin,
  input  wire logic                     cutoff_interrupt_pin,
  input  wire logic [CH-1:0]            capture_a,
  input  wire logic [CH-1:0]            capture_b,
  input  wire logic [CH-1:0]            capture_c_edge,
  input  wire logic [2*CH*2-1:0]        timer_wave,
  output logic      [2*CH*2-1:0]        timer_io_out,
  output logic      [2*CH*2-1:0]        timer_io_oe,
  output logic      [CH*CNT_W-1:0]      counter_value
);

  typedef struct packed {
    channel_s [CH-1:0]             ch;
    channel_control_reg_s [CH-1:0] ctrl;
    logic [3:0]                    func;
    logic [6:0]                    mode;
    logic [7:0]                    out_dis;
    logic                          cutoff_enable;
    logic [1:0]                    ext_sync;
    logic                          ext_prev;
    logic [31:0]                   rdata;
  } state_s;

  state_s st_q, st_d;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  logic        access;
  logic        wr;
  logic        ext_rise;
  logic        ext_fall;
  logic [2:0]  tmode;
  logic        buf_c [CH];
  logic        buf_d [CH];
  logic        tick [CH];
  logic        cnt_wr [CH];
  logic        clr_own [CH];
  logic        match_a [CH];
  logic        match_b [CH];
  logic        under1;
  logic        mapped;
  logic [31:0] rd;

  assign access   = psel && penable;
  assign wr       = access && pwrite;
  assign pready   = 1'b1;
  assign tmode    = st_q.func[FUNC_MODE_LSB +: 3];
  assign ext_rise = st_q.ext_sync[1] && !st_q.ext_prev;
  assign ext_fall = !st_q.ext_sync[1] && st_q.ext_prev;
  assign under1   = tick[1] && st_q.ch[1].channel_counter == '0 && tmode == MODE_COMPLEMENTARY;

  for (genvar i = 0; i < CH; i++) begin : g_ch
    logic [2:0] src;
    logic [1:0] edg;
    assign src = st_q.ctrl[i].count_source_select;
    assign edg = st_q.ctrl[i].ext_clock_edge_select;
    assign buf_c[i] = st_q.mode[MODE_BFC_LSB + i];
    assign buf_d[i] = st_q.mode[MODE_BFD_LSB + i];
    always_comb begin
      tick[i] = 1'b0;
      if (st_q.mode[MODE_START_LSB + i]) begin
        case (src)
          SRC_OSC40:   tick[i] = osc_40mhz_tick;
          SRC_FASTOSC: tick[i] = fast_osc_tick;
          SRC_EXT: begin
            if (st_q.func[FUNC_EXTCLK_BIT] && tmode != MODE_FIXED_PERIOD) begin
              tick[i] = edg == EDGE_RISE ? ext_rise : edg == EDGE_FALL ? ext_fall : (ext_rise || ext_fall);
            end
          end
          default:     tick[i] = sys_div_tick;
        endcase
      end
    end
    assign cnt_wr[i]  = wr && (hit(paddr, i == 0 ? OFF_CNT0 : OFF_CNT1) ||
                        (st_q.mode[MODE_SYNC_BIT] && (hit(paddr, OFF_CNT0) || hit(paddr, OFF_CNT1))));
    assign clr_own[i] = st_q.ctrl[i].counter_clear_source == CLR_CAPTURE_A && capture_a[i];
    assign match_a[i] = st_q.ch[i].channel_counter == st_q.ch[i].general_reg_a;
    assign match_b[i] = st_q.ch[i].channel_counter == st_q.ch[i].general_reg_b;
    for (genvar j = 0; j < 4; j++) begin : g_pin
      assign timer_io_oe[i*4+j]  = !st_q.out_dis[i*4+j];
      assign timer_io_out[i*4+j] = timer_wave[i*4+j] && !st_q.out_dis[i*4+j];
    end
    assign counter_value[i*CNT_W +: CNT_W] = st_q.ch[i].channel_counter;
  end

  always_comb begin
    mapped = 1'b1;
    rd     = '0;
    case (paddr)
      OFF_CH_CTRL0:    rd = 32'(st_q.ctrl[0]);
      OFF_CH_CTRL1:    rd = 32'(st_q.ctrl[1]);
      OFF_FUNC_CTRL:   rd = 32'(st_q.func);
      OFF_MODE_CTRL:   rd = 32'(st_q.mode);
      OFF_OUT_DISABLE: rd = 32'(st_q.out_dis);
      OFF_CUTOFF_CTRL: rd = 32'(st_q.cutoff_enable);
      OFF_FLAGS0:      rd = 32'(st_q.ch[0].channel_flag_reg);
      OFF_FLAGS1:      rd = 32'(st_q.ch[1].channel_flag_reg);
      OFF_CNT0:        rd = 32'(st_q.ch[0].channel_counter);
      OFF_CNT1:        rd = 32'(st_q.ch[1].channel_counter);
      default: begin
        if (paddr[11:5] == OFF_GR_BASE0[11:5]) begin
          case (paddr[3:2])
            2'h0:    rd = 32'(st_q.ch[paddr[4]].general_reg_a);
            2'h1:    rd = 32'(st_q.ch[paddr[4]].general_reg_b);
            2'h2:    rd = 32'(st_q.ch[paddr[4]].general_reg_c);
            default: rd = 32'(st_q.ch[paddr[4]].general_reg_d);
          endcase
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  assign pslverr = access && !mapped;
  assign prdata  = st_q.rdata;

  always_comb begin
    logic clr_any;
    logic sync_clr;
    logic reload_all;
    logic gr_wr;
    logic [1:0] gsel;
    logic       gch;
    clr_any    = clr_own[0] || clr_own[1];
    sync_clr   = 1'b0;
    reload_all = match_a[0] && tick[0];
    gr_wr      = wr && paddr[11:5] == OFF_GR_BASE0[11:5];
    gsel       = paddr[3:2];
    gch        = paddr[4];
    st_d       = st_q;
    st_d.ext_sync = {st_q.ext_sync[0], ext_count_clock_pin};
    st_d.ext_prev = st_q.ext_sync[1];
    // read word latched in setup so it stands through the access phase
    if (psel && !penable && !pwrite) begin
      st_d.rdata = rd;
    end
    if (wr) begin
      if (hit(paddr, OFF_CH_CTRL0))    st_d.ctrl[0]       = pwdata[7:0];
      if (hit(paddr, OFF_CH_CTRL1))    st_d.ctrl[1]       = pwdata[7:0];
      if (hit(paddr, OFF_FUNC_CTRL))   st_d.func          = pwdata[3:0];
      if (hit(paddr, OFF_MODE_CTRL))   st_d.mode          = pwdata[6:0];
      if (hit(paddr, OFF_OUT_DISABLE)) st_d.out_dis       = pwdata[7:0];
      if (hit(paddr, OFF_CUTOFF_CTRL)) st_d.cutoff_enable = pwdata[0];
      if (hit(paddr, OFF_FLAGS0))      st_d.ch[0].channel_flag_reg = st_q.ch[0].channel_flag_reg & pwdata[3:0];
      if (hit(paddr, OFF_FLAGS1))      st_d.ch[1].channel_flag_reg = st_q.ch[1].channel_flag_reg & pwdata[3:0];
    end
    for (int i = 0; i < CH; i++) begin
      if (clr_any && st_q.mode[MODE_SYNC_BIT] && st_q.ctrl[i].counter_clear_source == CLR_SYNC) begin
        sync_clr = 1'b1;
      end
    end
    for (int i = 0; i < CH; i++) begin
      if (cnt_wr[i]) begin
        st_d.ch[i].channel_counter = pwdata[CNT_W-1:0];
      end else if (clr_own[i] || (sync_clr && st_q.ctrl[i].counter_clear_source == CLR_SYNC)) begin
        st_d.ch[i].channel_counter = '0;
      end else if (tick[i]) begin
        st_d.ch[i].channel_counter = st_q.ch[i].channel_counter + 1'b1;
      end
      if (gr_wr && gch == 1'(i)) begin
        case (gsel)
          2'h0:    st_d.ch[i].general_reg_a = pwdata[CNT_W-1:0];
          2'h1:    st_d.ch[i].general_reg_b = pwdata[CNT_W-1:0];
          2'h2:    st_d.ch[i].general_reg_c = pwdata[CNT_W-1:0];
          default: st_d.ch[i].general_reg_d = pwdata[CNT_W-1:0];
        endcase
      end
      case (tmode)
        MODE_CAPTURE: begin
          if (capture_a[i] && buf_c[i]) st_d.ch[i].general_reg_c = st_q.ch[i].general_reg_a;
          if (capture_b[i] && buf_d[i]) st_d.ch[i].general_reg_d = st_q.ch[i].general_reg_b;
          if (capture_c_edge[i] && (buf_c[i] || buf_d[i])) st_d.ch[i].channel_flag_reg[3:2] = 2'h3;
        end
        MODE_TIMER, MODE_PWM: begin
          if (tick[i] && match_a[i] && buf_c[i]) st_d.ch[i].general_reg_a = st_q.ch[i].general_reg_c;
          if (tick[i] && match_b[i] && buf_d[i]) st_d.ch[i].general_reg_b = st_q.ch[i].general_reg_d;
        end
        MODE_RESET_SYNC, MODE_FIXED_PERIOD: begin
          if (reload_all && buf_c[i]) st_d.ch[i].general_reg_a = st_q.ch[i].general_reg_c;
          if (reload_all && buf_d[i]) st_d.ch[i].general_reg_b = st_q.ch[i].general_reg_d;
        end
        MODE_COMPLEMENTARY: begin
          if ((reload_all || under1) && buf_c[i] && i == 1) st_d.ch[i].general_reg_a = st_q.ch[i].general_reg_c;
          if ((reload_all || under1) && buf_d[i]) st_d.ch[i].general_reg_b = st_q.ch[i].general_reg_d;
        end
        default: ;
      endcase
      if (tmode != MODE_CAPTURE) begin
        if (buf_c[i] && st_q.ch[i].channel_counter == st_q.ch[i].general_reg_c) st_d.ch[i].channel_flag_reg[2] = 1'b1;
        if (buf_d[i] && st_q.ch[i].channel_counter == st_q.ch[i].general_reg_d) st_d.ch[i].channel_flag_reg[3] = 1'b1;
      end
    end
    if (st_q.cutoff_enable && !cutoff_interrupt_pin && tmode != MODE_CAPTURE) begin
      st_d.out_dis = OUT_DISABLE_RST;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q         <= '0;
      st_q.out_dis <= OUT_DISABLE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  chk_cutoff_disables: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_q.cutoff_enable && !cutoff_interrupt_pin && tmode != MODE_CAPTURE |=> st_q.out_dis == OUT_DISABLE_RST)
    else $error("cutoff did not disable outputs");
  chk_cutoff_latency: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_q.cutoff_enable && !cutoff_interrupt_pin && tmode != MODE_CAPTURE |-> ##[1:2] timer_io_oe == '0)
    else $error("cutoff latency exceeded");
  chk_pin_disable: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (timer_io_oe & st_q.out_dis) == '0)
    else $error("disabled pin still driven");
  chk_lockstep_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr && st_q.mode[MODE_SYNC_BIT] && hit(paddr, OFF_CNT0)
    |=> st_q.ch[0].channel_counter == st_q.ch[1].channel_counter)
    else $error("lockstep write diverged");
  chk_capture_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !cnt_wr[0] && clr_own[0] |=> st_q.ch[0].channel_counter == '0)
    else $error("capture clear missed");
  chk_sync_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !cnt_wr[1] && clr_own[0] && st_q.mode[MODE_SYNC_BIT] && st_q.ctrl[1].counter_clear_source == CLR_SYNC
    |=> st_q.ch[1].channel_counter == '0)
    else $error("lockstep clear missed");
  chk_ext_locked: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tmode == MODE_FIXED_PERIOD && st_q.ctrl[0].count_source_select == SRC_EXT |-> !tick[0])
    else $error("external clock used in fixed period mode");
  chk_ext_edge: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(st_q.ext_sync[1]) |=> ext_fall == 1'b0)
    else $error("edge detect error");
  chk_osc_source: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_q.mode[MODE_START_LSB] && st_q.ctrl[0].count_source_select == SRC_OSC40 |-> tick[0] == osc_40mhz_tick)
    else $error("oscillator source not followed");
  chk_fast_source: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_q.mode[MODE_START_LSB + 1] && st_q.ctrl[1].count_source_select == SRC_FASTOSC |-> tick[1] == fast_osc_tick)
    else $error("fast oscillator source not followed");
  chk_ext_rising: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_q.mode[MODE_START_LSB] && st_q.func[FUNC_EXTCLK_BIT] && tmode != MODE_FIXED_PERIOD &&
    st_q.ctrl[0].count_source_select == SRC_EXT && st_q.ctrl[0].ext_clock_edge_select == EDGE_RISE
    |-> tick[0] == ext_rise)
    else $error("external rising edge not counted");
  chk_capture_buffer: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tmode == MODE_CAPTURE && capture_a[0] && buf_c[0] |=> st_q.ch[0].general_reg_c == $past(st_q.ch[0].general_reg_a))
    else $error("capture did not fill buffer");
  chk_compare_reload: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (tmode == MODE_TIMER || tmode == MODE_PWM) && tick[0] && match_a[0] && buf_c[0]
    |=> st_q.ch[0].general_reg_a == $past(st_q.ch[0].general_reg_c))
    else $error("compare match did not reload");
  chk_compl_reload: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tmode == MODE_COMPLEMENTARY && ((match_a[0] && tick[0]) || under1) && buf_d[1]
    |=> st_q.ch[1].general_reg_b == $past(st_q.ch[1].general_reg_d))
    else $error("complementary reload missed");
  chk_capture_flags: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tmode == MODE_CAPTURE && capture_c_edge[0] && (buf_c[0] || buf_d[0]) |=> st_q.ch[0].channel_flag_reg[3:2] == 2'h3)
    else $error("capture flags not set");
  chk_match_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tmode != MODE_CAPTURE && buf_c[0] && st_q.ch[0].channel_counter == st_q.ch[0].general_reg_c
    |=> st_q.ch[0].channel_flag_reg[2])
    else $error("buffer match flag not set");

endmodule

/* File: dual_timer_common_control_test.sv */
// self-checking bench of the dual timer common control
module dual_timer_common_control_test;
  import dual_timer_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, slverr;
  logic        osc40, fast, div, ext_pin, cut_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, val;
  logic [1:0]  capture_a, capture_b, capture_c_edge;
  logic [7:0]  timer_wave, timer_io_out, timer_io_oe;
  logic [31:0] counter_value;
  logic [31:0] exp_q[$];
  string       name_q[$];
  int          fails, checks;

  dual_timer_common_control DUT (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_40mhz_tick(osc40), .fast_osc_tick(fast), .sys_div_tick(div), .ext_count_clock_pin(ext_pin),
    .cutoff_interrupt_pin(cut_pin), .capture_a(capture_a), .capture_b(capture_b),
    .capture_c_edge(capture_c_edge), .timer_wave(timer_wave), .timer_io_out(timer_io_out),
    .timer_io_oe(timer_io_oe), .counter_value(counter_value));

  dual_timer_far_side far (.sys_clk(sys_clk), .osc_40mhz_tick(osc40), .fast_osc_tick(fast),
    .sys_div_tick(div), .ext_count_clock_pin(ext_pin), .cutoff_interrupt_pin(cut_pin));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    slverr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    name_q.push_back(nm);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // read data stands in the access phase and is taken at the completing edge
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && pslverr !== 1'b1 && exp_q.size() > 0) begin
      chk(name_q.pop_front(), exp_q.pop_front(), prdata);
    end
  end

  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    capture_a = 2'h0; capture_b = 2'h0; capture_c_edge = 2'h0; slverr = 1'b0;
    fails = 0; checks = 0;
    void'($urandom(32'hFE52D366));
    timer_wave = 8'($urandom);
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    // reset values and an unmapped access
    rd(OFF_OUT_DISABLE, {24'h0, OUT_DISABLE_RST}, "out_disable");
    chk("counter_value", 32'h0, counter_value);
    apb(1'b0, 12'h100, 32'h0);
    chk("pslverr", 32'h1, {31'h0, slverr});
    $display("test reset done");
    // oscillator sources on both channels
    wr(OFF_CH_CTRL0, {29'h0, SRC_OSC40});
    wr(OFF_CH_CTRL1, {29'h0, SRC_FASTOSC});
    wr(OFF_MODE_CTRL, 32'h60);
    far.ticks(7, 11);
    repeat (3) @(posedge sys_clk);
    chk("counter_value", {16'd11, 16'd7}, counter_value);
    wr(OFF_MODE_CTRL, 32'h0);
    $display("test sources done");
    // external clock: rising, falling, both, then fixed-period mode
    for (int i = 0; i < 4; i++) begin
      wr(OFF_FUNC_CTRL, (i == 3) ? 32'hB : 32'h1);
      wr(OFF_CNT0, 32'h0);
      wr(OFF_CH_CTRL0, {27'h0, (i == 3) ? 2'h0 : 2'(i), SRC_EXT});
      wr(OFF_MODE_CTRL, 32'h20);
      far.ext_pulses(4);
      repeat (6) @(posedge sys_clk);
      wr(OFF_MODE_CTRL, 32'h0);
      chk("ext_count", (i == 3) ? 32'd0 : (i == 2) ? 32'd8 : 32'd4, {16'h0, counter_value[15:0]});
    end
    $display("test external clock done");
    // lockstep preset and synchronous clear on capture
    wr(OFF_FUNC_CTRL, 32'h2);
    wr(OFF_CH_CTRL0, 32'h0);
    wr(OFF_MODE_CTRL, 32'h1);
    val = {16'h0, 16'($urandom)};
    wr(OFF_CNT0, val);
    rd(OFF_CNT1, val, "counter1");
    wr(OFF_CH_CTRL0, {24'h0, CLR_CAPTURE_A, 5'h0});
    wr(OFF_CH_CTRL1, {24'h0, CLR_SYNC, 5'h0});
    wr(OFF_MODE_CTRL, 32'h61);
    @(posedge sys_clk); capture_a <= 2'h1;
    @(posedge sys_clk); capture_a <= 2'h0;
    repeat (3) @(posedge sys_clk);
    chk("counter_value", 32'h0, counter_value);
    $display("test lockstep done");
    // capture buffering and buffer flags
    wr(OFF_CH_CTRL0, 32'h0);
    wr(OFF_CH_CTRL1, 32'h0);
    wr(OFF_MODE_CTRL, 32'h0A);
    val = {16'h0, 16'($urandom)};
    wr(OFF_GR_BASE0, val);
    wr(OFF_GR_BASE0 + 12'h008, 32'h0);
    @(posedge sys_clk); capture_a <= 2'h1;
    @(posedge sys_clk); capture_a <= 2'h0;
    rd(OFF_GR_BASE0 + 12'h008, val, "buffer_c");
    wr(OFF_FLAGS0, 32'h0);
    @(posedge sys_clk); capture_c_edge <= 2'h1;
    @(posedge sys_clk); capture_c_edge <= 2'h0;
    rd(OFF_FLAGS0, 32'h0C, "flags0");
    $display("test capture buffer done");
    // compare buffering loads A from C on match
    wr(OFF_MODE_CTRL, 32'h0);
    wr(OFF_FUNC_CTRL, 32'h4);
    wr(OFF_CH_CTRL0, {29'h0, SRC_OSC40});
    wr(OFF_CNT0, 32'h0);
    wr(OFF_GR_BASE0, 32'h5);
    wr(OFF_GR_BASE0 + 12'h008, 32'h9);
    wr(OFF_MODE_CTRL, 32'h22);
    far.ticks(9, 0);
    wr(OFF_MODE_CTRL, 32'h0);
    rd(OFF_GR_BASE0, 32'h9, "general_a");
    $display("test compare buffer done");
    // complementary PWM reloads B0, A1 and B1 on zero-A match and underflow
    wr(OFF_FUNC_CTRL, 32'h8);
    wr(OFF_CH_CTRL1, {29'h0, SRC_OSC40});
    wr(OFF_CNT0, 32'h0);
    wr(OFF_GR_BASE0, 32'h2);
    wr(OFF_GR_BASE0 + 12'h00C, 32'h11);
    wr(OFF_GR_BASE1 + 12'h008, 32'h22);
    wr(OFF_GR_BASE1 + 12'h00C, 32'h33);
    wr(OFF_MODE_CTRL, 32'h7C);
    far.ticks(4, 0);
    wr(OFF_MODE_CTRL, 32'h0);
    rd(OFF_GR_BASE0 + 12'h004, 32'h11, "general_b0");
    rd(OFF_GR_BASE1, 32'h22, "general_a1");
    rd(OFF_GR_BASE1 + 12'h004, 32'h33, "general_b1");
    $display("test complementary done");
    // output enable and forced cutoff
    wr(OFF_OUT_DISABLE, 32'h0);
    wr(OFF_CUTOFF_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("timer_io_oe", 32'hFF, {24'h0, timer_io_oe});
    chk("timer_io_out", {24'h0, timer_wave}, {24'h0, timer_io_out});
    far.cutoff(1'b0);
    repeat (2) @(posedge sys_clk);
    chk("timer_io_oe", 32'h0, {24'h0, timer_io_oe});
    far.cutoff(1'b1);
    rd(OFF_OUT_DISABLE, 32'hFF, "out_disable");
    repeat (3) @(posedge sys_clk);
    $display("test cutoff done");
    results();
  end
endmodule

/* File: dual_timer_far_side.sv */
// far-side model: oscillator ticks, external count clock and cutoff pin
module dual_timer_far_side (
  input  wire logic sys_clk,
  output logic      osc_40mhz_tick,
  output logic      fast_osc_tick,
  output logic      sys_div_tick,
  output logic      ext_count_clock_pin,
  output logic      cutoff_interrupt_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    osc_40mhz_tick       = 1'b0;
    fast_osc_tick        = 1'b0;
    sys_div_tick         = 1'b0;
    ext_count_clock_pin  = 1'b0;
    cutoff_interrupt_pin = 1'b1;
  end

  // oscillators only tick once software has them running
  task automatic ticks(input int n0, input int n1);
    for (int i = 0; i < n0 || i < n1; i++) begin
      @(posedge sys_clk);
      osc_40mhz_tick <= (i < n0);
      fast_osc_tick  <= (i < n1);
    end
    @(posedge sys_clk);
    osc_40mhz_tick <= 1'b0;
    fast_osc_tick  <= 1'b0;
  endtask

  // high and low phases of three operation clocks, pin rests low
  task automatic ext_pulses(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      ext_count_clock_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ext_count_clock_pin <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask

  // pin read unfiltered as a low-active level, level given by caller
  task automatic cutoff(input logic lvl);
    @(posedge sys_clk);
    cutoff_interrupt_pin <= lvl;
  endtask
endmodule

/* File: dual_timer_pkg.sv */
// package: register map, field layout and types of the dual timer common control
package dual_timer_pkg;

  localparam int          CHANNELS           = 2;
  localparam int          CNT_W              = 16;
  localparam logic [11:0] OFF_CH_CTRL0       = 12'h000;
  localparam logic [11:0] OFF_CH_CTRL1       = 12'h004;
  localparam logic [11:0] OFF_FUNC_CTRL      = 12'h008;
  localparam logic [11:0] OFF_MODE_CTRL      = 12'h00C;
  localparam logic [11:0] OFF_OUT_DISABLE    = 12'h010;
  localparam logic [11:0] OFF_CUTOFF_CTRL    = 12'h014;
  localparam logic [11:0] OFF_FLAGS0         = 12'h018;
  localparam logic [11:0] OFF_FLAGS1         = 12'h01C;
  localparam logic [11:0] OFF_CNT0           = 12'h020;
  localparam logic [11:0] OFF_CNT1           = 12'h024;
  localparam logic [11:0] OFF_GR_BASE0       = 12'h040;
  localparam logic [11:0] OFF_GR_BASE1       = 12'h050;
  localparam int          CH_SRC_LSB         = 0;
  localparam int          CH_EDGE_LSB        = 3;
  localparam int          CH_CLR_LSB         = 5;
  localparam int          MODE_SYNC_BIT      = 0;
  localparam int          MODE_BFC_LSB       = 1;
  localparam int          MODE_BFD_LSB       = 3;
  localparam int          MODE_START_LSB     = 5;
  localparam int          FUNC_EXTCLK_BIT    = 0;
  localparam int          FUNC_MODE_LSB      = 1;
  localparam logic [2:0]  SRC_EXT            = 3'h5;
  localparam logic [2:0]  SRC_OSC40          = 3'h6;
  localparam logic [2:0]  SRC_FASTOSC        = 3'h7;
  localparam logic [2:0]  CLR_NONE           = 3'h0;
  localparam logic [2:0]  CLR_CAPTURE_A      = 3'h1;
  localparam logic [2:0]  CLR_SYNC           = 3'h3;
  localparam logic [7:0]  OUT_DISABLE_RST    = 8'hFF;
  localparam logic [1:0]  EDGE_RISE          = 2'h0;
  localparam logic [1:0]  EDGE_FALL          = 2'h1;
  localparam int          CUTOFF_CYCLES_MAX  = 2;

  typedef enum logic [2:0] {
    MODE_TIMER, MODE_CAPTURE, MODE_PWM, MODE_RESET_SYNC, MODE_COMPLEMENTARY, MODE_FIXED_PERIOD
  } timer_mode_e;

  typedef struct packed {
    logic [2:0] counter_clear_source;
    logic [1:0] ext_clock_edge_select;
    logic [2:0] count_source_select;
  } channel_control_reg_s;

  typedef struct packed {
    logic [CNT_W-1:0] general_reg_a;
    logic [CNT_W-1:0] general_reg_b;
    logic [CNT_W-1:0] general_reg_c;
    logic [CNT_W-1:0] general_reg_d;
    logic [CNT_W-1:0] channel_counter;
    logic [3:0]       channel_flag_reg;
  } channel_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             under;
  } count_evt_s;

endpackage
